// ### logic/irq_entry_defines.svh
// Constants for the interrupt and exception entry block
`ifndef IRQ_ENTRY_DEFINES_SVH
`define IRQ_ENTRY_DEFINES_SVH

`define VECTOR_COUNT 256
`define RESERVED_VECTORS 32
`define SYSTEM_VECTORS 224
`define VEC_DEBUG 8'h01
`define VEC_NMI 8'h02
`define VEC_BREAKPOINT 8'h03

`define REAL_ENTRY_BYTES 32'h0000_0004
`define PROT_ENTRY_BYTES 32'h0000_0008
`define STACK_SLOT_BYTES 32'h0000_0004
`define STACK_FRAME_BYTES 32'h0000_0008

`define FLAGS_IF_BIT 9
`define FLAGS_RESET 32'h0000_0002
`define STACK_RESET 32'h0000_0000

`endif

// ### logic/irq_entry_pkg.sv
// Types shared by the interrupt and exception entry block
package irq_entry_pkg;

	typedef enum logic [2:0] {
		EV_FAULT = 3'h0,
		EV_TRAP = 3'h1,
		EV_ABORT = 3'h2,
		EV_SOFT = 3'h3,
		EV_BREAKPOINT = 3'h4,
		EV_MASKABLE = 3'h5,
		EV_NMI = 3'h6
	} event_kind_type;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_PUSH_ADDR = 4'h1,
		ST_PUSH_FLAGS = 4'h2,
		ST_ACK = 4'h3,
		ST_TABLE_LO = 4'h4,
		ST_TABLE_HI = 4'h5,
		ST_DISPATCH = 4'h6,
		ST_POP_FLAGS = 4'h7,
		ST_POP_ADDR = 4'h8,
		ST_RESUME = 4'h9
	} state_type;

	// Exception reported by the execution stage
	typedef struct packed {
		event_kind_type kind;
		logic [7:0] vector;
		logic [31:0] addr;
	} exc_event_type;

	// Word access to stack or vector table
	typedef struct packed {
		logic write;
		logic [31:0] addr;
		logic [31:0] wdata;
	} mem_req_type;

	// Handler start handed to the fetch stage
	typedef struct packed {
		logic [31:0] addr;
		logic [15:0] selector;
		logic [7:0] vector;
		event_kind_type kind;
		logic imprecise;
	} handler_type;

endpackage : irq_entry_pkg

// ### logic/sync_two_flop.sv
// Two-flop synchroniser for one level input
`timescale 1ns/1ps
module sync_two_flop (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Level in and out
	input wire logic din,
	output logic dout
);
	logic meta_reg;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_reg <= 1'b0;
			dout <= 1'b0;
		end else begin
			meta_reg <= din;
			dout <= meta_reg;
		end
	end
endmodule : sync_two_flop

// ### logic/interrupt_exception_entry.sv
// Interrupt and exception entry, vector fetch and interrupt return
`timescale 1ns/1ps
`include "irq_entry_defines.svh"

// What this block does
// - Hardware interrupts wait for instruction end, resume after
// - Faults save address of faulting instruction start
// - Traps save address past the causing instruction
// - Aborts flagged imprecise, no exact location kept
// - 256 vectors, 32 reserved, 224 for system
// - Real mode 4-byte entries, protected 8-byte
// - Push address and flags, get vector, dispatch
// - Interrupt return restores flags and saved address
// - Exceptions internal vector, maskable via acknowledge
// - Non-maskable uses vector 2, no acknowledge
// - Maskable pin taken only with enable flag set
// - Requests at boundaries or string move windows
// - Maskable entry clears enable flag, return restores
// - Further non-maskable not taken until return or reset
// - One non-maskable latched during service, taken later
// - Non-maskable entry clears the enable flag
// - Soft interrupt uses vector n, breakpoint 3
// - Non-maskable before maskable at same boundary
// - Debug traps and faults checked before pins
module interrupt_exception_entry
	import irq_entry_pkg::*;
#(
	parameter int VECTORS = `VECTOR_COUNT,
	parameter int RESERVED = `RESERVED_VECTORS
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Request pins from the interrupt controller
	input wire logic maskable_request_pin,
	input wire logic nonmaskable_request_pin,
	// Interrupt acknowledge sequence
	output logic ack_req,
	input wire logic ack_done,
	input wire logic [7:0] ack_vector,
	// Execution stage
	input wire logic boundary,
	input wire logic string_window,
	input wire logic [31:0] cur_addr,
	input wire logic [31:0] next_addr,
	input wire logic exc_valid,
	input wire exc_event_type exc_event,
	input wire logic debug_trap,
	input wire logic debug_fault,
	input wire logic interrupt_return_instr,
	input wire logic protected_mode,
	input wire logic [31:0] table_base,
	output logic busy,
	// Flags and stack pointer
	input wire logic flags_we,
	input wire logic [31:0] flags_wdata,
	output logic [31:0] flags_word,
	input wire logic sp_we,
	input wire logic [31:0] sp_wdata,
	output logic [31:0] stack_ptr,
	// Memory port for stack and vector table
	output logic mem_valid,
	output mem_req_type mem_req,
	input wire logic mem_ready,
	input wire logic [31:0] mem_rdata,
	// Handler start and resume
	output logic handler_valid,
	output handler_type handler,
	output logic resume_valid,
	output logic [31:0] resume_addr
);

	generate
		if (VECTORS != 256 || RESERVED != 32 || VECTORS - RESERVED != `SYSTEM_VECTORS) begin : g_chk
			$error("vector table must hold 256 entries with 32 reserved");
		end
	endgenerate

	state_type state_reg;
	state_type state_next;
	logic maskable_sync;
	logic nmi_sync;
	logic nmi_prev_reg;
	logic nmi_req_reg;
	logic nmi_active_reg;
	logic nmi_pending_reg;
	logic [31:0] flags_reg;
	logic [31:0] flags_cur;
	logic [31:0] saved_flags_reg;
	logic [31:0] save_addr_reg;
	logic [31:0] sp_reg;
	logic [31:0] lo_word_reg;
	logic [7:0] vector_reg;
	logic [7:0] vec_now;
	event_kind_type kind_reg;
	logic imprecise_reg;
	mem_req_type mem_req_reg;
	handler_type handler_reg;
	logic [31:0] resume_reg;
	logic nmi_edge;
	logic at_point;
	logic take_exc;
	logic take_interrupt_return_instr;
	logic start;
	logic take_nmi;
	logic interrupt_return_instr_done;
	event_kind_type start_kind;
	logic [7:0] start_vector;
	logic [31:0] start_addr;
	logic start_imprecise;

	// Pins cross into the core clock before any decision
	sync_two_flop u_sync_maskable (
		.clk(clk),
		.rstn(rstn),
		.din(maskable_request_pin),
		.dout(maskable_sync)
	);

	sync_two_flop u_sync_nmi (
		.clk(clk),
		.rstn(rstn),
		.din(nonmaskable_request_pin),
		.dout(nmi_sync)
	);

	assign nmi_edge = nmi_sync & ~nmi_prev_reg;
	assign flags_cur = flags_we ? flags_wdata : flags_reg;

	// Exceptions first, then return, then the boundary checks
	assign take_exc = (state_reg == ST_IDLE) && exc_valid;
	assign take_interrupt_return_instr = (state_reg == ST_IDLE) && !exc_valid && interrupt_return_instr;
	assign at_point = (state_reg == ST_IDLE) && !exc_valid && !interrupt_return_instr
		&& (boundary || string_window);
	assign interrupt_return_instr_done = (state_reg == ST_POP_ADDR) && mem_ready;

	always_comb begin
		start = 1'b0;
		take_nmi = 1'b0;
		start_kind = EV_FAULT;
		start_vector = 8'h00;
		start_addr = next_addr;
		start_imprecise = 1'b0;
		if (take_exc) begin
			start = 1'b1;
			start_kind = exc_event.kind;
			start_vector = exc_event.vector;
			unique case (exc_event.kind)
				EV_FAULT: start_addr = exc_event.addr;
				EV_ABORT: begin
					start_addr = cur_addr;
					start_imprecise = 1'b1;
				end
				EV_BREAKPOINT: start_vector = `VEC_BREAKPOINT;
				default: start_addr = next_addr;
			endcase
		end else if (at_point) begin
			// Mid string move the instruction itself resumes
			start_addr = boundary ? next_addr : cur_addr;
			if (boundary && debug_trap) begin
				start = 1'b1;
				start_kind = EV_TRAP;
				start_vector = `VEC_DEBUG;
			end else if (boundary && debug_fault) begin
				start = 1'b1;
				start_kind = EV_FAULT;
				start_vector = `VEC_DEBUG;
			end else if (nmi_req_reg && !nmi_active_reg) begin
				start = 1'b1;
				take_nmi = 1'b1;
				start_kind = EV_NMI;
				start_vector = `VEC_NMI;
			end else if (maskable_sync && flags_cur[`FLAGS_IF_BIT]) begin
				start = 1'b1;
				start_kind = EV_MASKABLE;
			end
		end
	end

	assign vec_now = (state_reg == ST_ACK) ? ack_vector : vector_reg;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (start) begin
					state_next = ST_PUSH_ADDR;
				end else if (take_interrupt_return_instr) begin
					state_next = ST_POP_FLAGS;
				end
			end
			ST_PUSH_ADDR: begin
				if (mem_ready) begin
					state_next = ST_PUSH_FLAGS;
				end
			end
			ST_PUSH_FLAGS: begin
				if (mem_ready) begin
					// Only maskable requests run the acknowledge
					state_next = (kind_reg == EV_MASKABLE) ? ST_ACK : ST_TABLE_LO;
				end
			end
			ST_ACK: begin
				if (ack_done) begin
					state_next = ST_TABLE_LO;
				end
			end
			ST_TABLE_LO: begin
				if (mem_ready) begin
					state_next = protected_mode ? ST_TABLE_HI : ST_DISPATCH;
				end
			end
			ST_TABLE_HI: begin
				if (mem_ready) begin
					state_next = ST_DISPATCH;
				end
			end
			ST_DISPATCH: state_next = ST_IDLE;
			ST_POP_FLAGS: begin
				if (mem_ready) begin
					state_next = ST_POP_ADDR;
				end
			end
			ST_POP_ADDR: begin
				if (mem_ready) begin
					state_next = ST_RESUME;
				end
			end
			ST_RESUME: state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Event capture at entry
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			kind_reg <= EV_FAULT;
			vector_reg <= 8'h00;
			save_addr_reg <= 32'h0000_0000;
			saved_flags_reg <= `FLAGS_RESET;
			imprecise_reg <= 1'b0;
		end else if (start) begin
			kind_reg <= start_kind;
			vector_reg <= start_vector;
			save_addr_reg <= start_addr;
			saved_flags_reg <= flags_cur;
			imprecise_reg <= start_imprecise;
		end else if (state_reg == ST_ACK && ack_done) begin
			vector_reg <= ack_vector;
		end
	end

	// Flags: maskable and non-maskable entry clear the enable, return restores the saved word
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flags_reg <= `FLAGS_RESET;
		end else if (state_reg == ST_POP_FLAGS && mem_ready) begin
			flags_reg <= mem_rdata;
		end else if (start && (start_kind == EV_MASKABLE || start_kind == EV_NMI)) begin
			flags_reg <= flags_cur & ~(32'h0000_0001 << `FLAGS_IF_BIT);
		end else if (flags_we) begin
			flags_reg <= flags_wdata;
		end
	end

	// Non-maskable edge tracking; a new edge beats a clear
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			nmi_prev_reg <= 1'b0;
			nmi_req_reg <= 1'b0;
			nmi_active_reg <= 1'b0;
			nmi_pending_reg <= 1'b0;
		end else begin
			nmi_prev_reg <= nmi_sync;
			if (interrupt_return_instr_done) begin
				nmi_active_reg <= 1'b0;
				if (nmi_pending_reg || nmi_edge) begin
					nmi_req_reg <= 1'b1;
					nmi_pending_reg <= 1'b0;
				end
			end else if (take_nmi) begin
				nmi_active_reg <= 1'b1;
				nmi_req_reg <= 1'b0;
				if (nmi_edge) begin
					nmi_pending_reg <= 1'b1;
				end
			end else if (nmi_edge) begin
				// Only one extra request is remembered
				if (nmi_active_reg) begin
					nmi_pending_reg <= 1'b1;
				end else begin
					nmi_req_reg <= 1'b1;
				end
			end
		end
	end

	// Stack pointer moves once per frame
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sp_reg <= `STACK_RESET;
		end else if (state_reg == ST_DISPATCH) begin
			sp_reg <= sp_reg - `STACK_FRAME_BYTES;
		end else if (state_reg == ST_RESUME) begin
			sp_reg <= sp_reg + `STACK_FRAME_BYTES;
		end else if (sp_we && state_reg == ST_IDLE) begin
			sp_reg <= sp_wdata;
		end
	end

	// Memory request registered for the state being entered
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mem_req_reg <= '0;
		end else begin
			unique case (state_next)
				ST_PUSH_ADDR: begin
					mem_req_reg.write <= 1'b1;
					mem_req_reg.addr <= sp_reg - `STACK_SLOT_BYTES;
					mem_req_reg.wdata <= start ? start_addr : save_addr_reg;
				end
				ST_PUSH_FLAGS: begin
					mem_req_reg.write <= 1'b1;
					mem_req_reg.addr <= sp_reg - `STACK_FRAME_BYTES;
					mem_req_reg.wdata <= saved_flags_reg;
				end
				ST_TABLE_LO: begin
					mem_req_reg.write <= 1'b0;
					mem_req_reg.wdata <= 32'h0000_0000;
					if (protected_mode) begin
						mem_req_reg.addr <= table_base + {21'h0, vec_now, 3'h0};
					end else begin
						mem_req_reg.addr <= table_base + {22'h0, vec_now, 2'h0};
					end
				end
				ST_TABLE_HI: begin
					mem_req_reg.write <= 1'b0;
					// Step once on leaving the low word; a stall must not move it
					if (state_reg == ST_TABLE_LO) begin
						mem_req_reg.addr <= mem_req_reg.addr + `STACK_SLOT_BYTES;
					end
				end
				ST_POP_FLAGS: begin
					mem_req_reg.write <= 1'b0;
					mem_req_reg.addr <= sp_reg;
					mem_req_reg.wdata <= 32'h0000_0000;
				end
				ST_POP_ADDR: begin
					mem_req_reg.write <= 1'b0;
					mem_req_reg.addr <= sp_reg + `STACK_SLOT_BYTES;
				end
				default: mem_req_reg.write <= 1'b0;
			endcase
		end
	end

	// Handler assembly from the table entry
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lo_word_reg <= 32'h0000_0000;
			handler_reg <= '0;
		end else if (state_reg == ST_TABLE_LO && mem_ready) begin
			lo_word_reg <= mem_rdata;
			// Real mode entry: offset low half, segment high half
			handler_reg.addr <= {16'h0000, mem_rdata[15:0]};
			handler_reg.selector <= mem_rdata[31:16];
			handler_reg.vector <= vector_reg;
			handler_reg.kind <= kind_reg;
			handler_reg.imprecise <= imprecise_reg;
		end else if (state_reg == ST_TABLE_HI && mem_ready) begin
			handler_reg.addr <= {mem_rdata[31:16], lo_word_reg[15:0]};
		end
	end

	// Resume address from the popped frame
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			resume_reg <= 32'h0000_0000;
		end else if (interrupt_return_instr_done) begin
			resume_reg <= mem_rdata;
		end
	end

	assign busy = (state_reg != ST_IDLE);
	assign ack_req = (state_reg == ST_ACK);
	assign mem_valid = (state_reg == ST_PUSH_ADDR) || (state_reg == ST_PUSH_FLAGS)
		|| (state_reg == ST_TABLE_LO) || (state_reg == ST_TABLE_HI)
		|| (state_reg == ST_POP_FLAGS) || (state_reg == ST_POP_ADDR);
	assign mem_req = mem_req_reg;
	assign handler_valid = (state_reg == ST_DISPATCH);
	assign handler = handler_reg;
	assign resume_valid = (state_reg == ST_RESUME);
	assign resume_addr = resume_reg;
	assign flags_word = flags_reg;
	assign stack_ptr = sp_reg;

endmodule : interrupt_exception_entry

// ### sim/irq_entry_props.sv
// Port assertions for the interrupt and exception entry block
`timescale 1ns/1ps
`include "irq_entry_defines.svh"
module irq_entry_props
	import irq_entry_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Watched ports
	input wire logic exc_valid,
	input wire logic interrupt_return_instr,
	input wire logic busy,
	input wire logic ack_req,
	input wire logic ack_done,
	input wire logic mem_valid,
	input wire mem_req_type mem_req,
	input wire logic mem_ready,
	input wire logic [31:0] stack_ptr,
	input wire logic [31:0] flags_word,
	input wire logic handler_valid,
	input wire handler_type handler,
	input wire logic resume_valid
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_push_addr;
		mem_valid && mem_req.write && mem_req.addr == stack_ptr - 32'h0000_0004;
	endsequence
	sequence s_pop_flags;
		mem_valid && !mem_req.write && mem_req.addr == stack_ptr;
	endsequence
	property p_exc_push;
		exc_valid && !busy |=> s_push_addr;
	endproperty
	a_exc_push: assert property (p_exc_push) else $error("entry did not push address");
	property p_entry_done;
		exc_valid && !busy |-> ##[4:300] handler_valid;
	endproperty
	a_entry_done: assert property (p_entry_done) else $error("handler start missing");
	property p_ret_pop;
		interrupt_return_instr && !busy && !exc_valid |=> s_pop_flags ##[1:300] resume_valid;
	endproperty
	a_ret_pop: assert property (p_ret_pop) else $error("return did not pop frame");
	property p_ack_hold;
		ack_req && !ack_done |=> ack_req;
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("acknowledge dropped early");
	property p_mem_hold;
		mem_valid && !mem_ready |=> mem_valid && $stable(mem_req);
	endproperty
	a_mem_hold: assert property (p_mem_hold) else $error("memory request not held");
	property p_nmi_vec;
		handler_valid && handler.kind == EV_NMI |-> handler.vector == 8'h02;
	endproperty
	a_nmi_vec: assert property (p_nmi_vec) else $error("non-maskable vector wrong");
	property p_bp_vec;
		handler_valid && handler.kind == EV_BREAKPOINT |-> handler.vector == 8'h03;
	endproperty
	a_bp_vec: assert property (p_bp_vec) else $error("breakpoint vector wrong");
	property p_if_clear;
		handler_valid && handler.kind inside {EV_MASKABLE, EV_NMI} |-> !flags_word[`FLAGS_IF_BIT];
	endproperty
	a_if_clear: assert property (p_if_clear) else $error("enable flag left set");
	property p_hv_pulse;
		handler_valid |=> !handler_valid [*4];
	endproperty
	a_hv_pulse: assert property (p_hv_pulse) else $error("handler start too long");
endmodule : irq_entry_props

// ### sim/irq_controller_model.sv
// Behavioural model of the external interrupt controller
`timescale 1ns/1ps
module irq_controller_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Commands from the bench
	input wire logic raise_m,
	input wire logic raise_n,
	input wire logic slow,
	input wire logic [7:0] next_vector,
	// Pins and acknowledge towards the core
	output logic maskable_request_pin,
	output logic nonmaskable_request_pin,
	input wire logic ack_req,
	output logic ack_done,
	output logic [7:0] ack_vector
);
	logic [1:0] wait_reg;
	assign maskable_request_pin = raise_m;
	assign nonmaskable_request_pin = raise_n;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ack_done <= 1'b0;
			ack_vector <= 8'h00;
			wait_reg <= 2'h0;
		end else if (ack_req && !ack_done && (!slow || wait_reg == 2'h3)) begin
			ack_done <= 1'b1;
			ack_vector <= next_vector;
			wait_reg <= 2'h0;
		end else begin
			ack_done <= 1'b0;
			// Valid only with the pulse, so scramble it otherwise
			ack_vector <= ~ack_vector;
			wait_reg <= ack_req ? wait_reg + 2'h1 : 2'h0;
		end
	end
endmodule : irq_controller_model

// ### sim/interrupt_exception_entry_bench.sv
// Self-checking bench for the interrupt and exception entry block
`timescale 1ns/1ps
`include "irq_entry_defines.svh"
module interrupt_exception_entry_bench;
	import irq_entry_pkg::*;
	logic clk, rstn, boundary, string_window, exc_valid, debug_trap, debug_fault, mem_ready;
	logic interrupt_return_instr, protected_mode, flags_we, sp_we, ack_req, busy, ack_done;
	logic maskable_request_pin, nonmaskable_request_pin, raise_m, raise_n, slow, ack_seen;
	logic mem_valid, handler_valid, resume_valid;
	logic [7:0] ack_vector, pvec;
	logic [31:0] cur_addr, next_addr, table_base, flags_wdata, sp_wdata, mem_rdata;
	logic [31:0] flags_word, stack_ptr, resume_addr, sv_addr, sv_fl, sv_sp;
	exc_event_type exc_event;
	mem_req_type mem_req;
	handler_type handler;
	logic [31:0] mem [0:2047];
	int error_cnt, checked;
	interrupt_exception_entry i_interrupt_exception_entry (.clk, .rstn, .maskable_request_pin,
		.nonmaskable_request_pin, .ack_req, .ack_done, .ack_vector, .boundary, .string_window,
		.cur_addr, .next_addr, .exc_valid, .exc_event, .debug_trap, .debug_fault,
		.interrupt_return_instr, .protected_mode, .table_base, .busy, .flags_we, .flags_wdata,
		.flags_word, .sp_we, .sp_wdata, .stack_ptr, .mem_valid, .mem_req, .mem_ready,
		.mem_rdata, .handler_valid, .handler, .resume_valid, .resume_addr);
	irq_controller_model i_irq_controller_model (.clk, .rstn, .raise_m, .raise_n, .slow,
		.next_vector(pvec), .maskable_request_pin, .nonmaskable_request_pin, .ack_req,
		.ack_done, .ack_vector);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Stack and vector table memory with random stalls
	assign mem_rdata = mem[mem_req.addr[12:2]];
	always @(posedge clk) begin
		if (mem_valid && mem_ready && mem_req.write)
			mem[mem_req.addr[12:2]] <= mem_req.wdata;
		if (ack_req)
			ack_seen <= 1'b1;
	end
	always @(negedge clk)
		mem_ready <= ($urandom % 4) != 0;
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task wait_for(input bit res);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (!(res ? resume_valid === 1'b1 : handler_valid === 1'b1) && n < 400);
		chk("completion", n < 400, 1);
		@(negedge clk);
	endtask : wait_for
	task pulse(input logic [2:0] sel);
		{exc_valid, boundary, string_window} = sel;
		@(negedge clk);
		{exc_valid, boundary, string_window} = 3'h0;
	endtask : pulse
	task quiet(input int n);
		repeat (n) begin
			@(negedge clk);
			chk("no entry", handler_valid, 0);
		end
	endtask : quiet
	task entry(input int how, input logic [7:0] v, input event_kind_type k,
			input logic [31:0] saved, input logic if_after);
		logic [31:0] w0, w1;
		sv_sp = stack_ptr;
		sv_fl = flags_word;
		sv_addr = saved;
		ack_seen = 1'b0;
		pvec = v;
		pulse(3'h4 >> how);
		wait_for(0);
		w0 = protected_mode ? mem[{2'h0, v, 1'b0}] : mem[{3'h0, v}];
		w1 = protected_mode ? mem[{2'h0, v, 1'b1}] : 32'h0;
		chk("vector", handler.vector, v);
		chk("kind", handler.kind, k);
		chk("offset", handler.addr, {w1[31:16], w0[15:0]});
		chk("selector", handler.selector, w0[31:16]);
		chk("saved addr", mem[sv_sp[12:2] - 11'h1], saved);
		chk("saved flags", mem[sv_sp[12:2] - 11'h2], sv_fl);
		chk("sp", stack_ptr, sv_sp - `STACK_FRAME_BYTES);
		chk("if flag", flags_word[`FLAGS_IF_BIT], if_after);
		chk("ack", ack_seen, k == EV_MASKABLE);
		chk("imprecise", handler.imprecise, k == EV_ABORT);
	endtask : entry
	task ret;
		interrupt_return_instr = 1'b1;
		@(negedge clk);
		interrupt_return_instr = 1'b0;
		wait_for(1);
		chk("resume", resume_addr, sv_addr);
		chk("flags back", flags_word, sv_fl);
		chk("sp back", stack_ptr, sv_sp);
	endtask : ret
	task do_reset(input int n);
		rstn = 1'b0;
		repeat (n) @(negedge clk);
		rstn = 1'b1;
		chk("flags reset", flags_word, `FLAGS_RESET);
		chk("sp reset", stack_ptr, `STACK_RESET);
		chk("busy reset", busy, 0);
		{sp_we, sp_wdata, flags_we, flags_wdata} = {1'b1, 32'h0000_1f00, 1'b1, 32'h0000_0202};
		@(negedge clk);
		{sp_we, flags_we} = 2'h0;
	endtask : do_reset
	task wrap_up;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up
	initial begin
		#2000000;
		error_cnt++;
		wrap_up();
	end
	initial begin
		void'($urandom(41278));
		{rstn, boundary, string_window, exc_valid, debug_trap, debug_fault} = 6'h00;
		{interrupt_return_instr, protected_mode, flags_we, sp_we, raise_m, raise_n} = 6'h00;
		{cur_addr, next_addr, table_base, flags_wdata, sp_wdata} = '0;
		{slow, ack_seen, pvec, exc_event} = '0;
		{mem_ready, error_cnt, checked} = '0;
		for (int i = 0; i < 2048; i++)
			mem[i] = $urandom;
		do_reset(6);
		// Maskable entries, prompt and slow controller, both table formats
		for (int i = 0; i < 8; i++) begin
			{cur_addr, next_addr, slow, protected_mode} = {$urandom, $urandom, i[0], i > 5};
			raise_m = 1'b1;
			repeat (3) @(negedge clk);
			entry(1 + i % 2, 8'd32 + 8'($urandom % 224), EV_MASKABLE,
				i % 2 ? cur_addr : next_addr, 0);
			raise_m = 1'b0;
			ret();
		end
		protected_mode = 1'b0;
		// Every exception kind, breakpoint given a wrong vector on purpose
		for (int k = 0; k < 5; k++) begin
			exc_event = {event_kind_type'(k), 8'($urandom), $urandom};
			{cur_addr, next_addr} = {$urandom, $urandom};
			entry(0, k == 4 ? `VEC_BREAKPOINT : exc_event.vector, exc_event.kind,
				k == 0 ? exc_event.addr : k == 2 ? cur_addr : next_addr, 1);
			ret();
		end
		// Pin raised together with the boundary is still in the synchroniser
		raise_m = 1'b1;
		pulse(3'h2);
		quiet(6);
		// Trap beats fault, and both beat the pending maskable pin
		{debug_trap, debug_fault} = 2'h3;
		entry(1, `VEC_DEBUG, EV_TRAP, next_addr, 1);
		debug_trap = 1'b0;
		ret();
		entry(1, `VEC_DEBUG, EV_FAULT, next_addr, 1);
		debug_fault = 1'b0;
		ret();
		raise_n = 1'b1;
		repeat (3) @(negedge clk);
		entry(1, `VEC_NMI, EV_NMI, next_addr, 0);
		raise_n = 1'b0;
		repeat (3) @(negedge clk);
		raise_n = 1'b1;
		repeat (3) @(negedge clk);
		pulse(3'h2);
		quiet(8);
		ret();
		entry(1, `VEC_NMI, EV_NMI, next_addr, 0);
		raise_n = 1'b0;
		ret();
		// Maskable pin still high, enable restored by the return
		entry(1, 8'd32 + 8'($urandom % 224), EV_MASKABLE, next_addr, 0);
		raise_m = 1'b0;
		ret();
		// Reset in mid service frees the non-maskable path again
		raise_n = 1'b1;
		repeat (3) @(negedge clk);
		entry(1, `VEC_NMI, EV_NMI, next_addr, 0);
		do_reset(2);
		repeat (3) @(negedge clk);
		entry(1, `VEC_NMI, EV_NMI, next_addr, 0);
		wrap_up();
	end
endmodule : interrupt_exception_entry_bench
bind interrupt_exception_entry irq_entry_props i_irq_entry_props (.clk, .rstn, .exc_valid,
	.interrupt_return_instr, .busy, .ack_req, .ack_done, .mem_valid, .mem_req, .mem_ready,
	.stack_ptr, .flags_word, .handler_valid, .handler, .resume_valid);
